// ===== core/srl_pkg.sv
// srl_pkg: field layouts, select codes, reset values and states of the synthesizer config block
package srl_pkg;
  // ************************************************
  // widths and select codes
  // ************************************************
  localparam int WORD_W = 32; // programming word width
  localparam int R_W = 10; // reference divider width
  localparam logic [3:0] SEL_FREQ = 4'h0; // frequency word, applies settings
  localparam logic [3:0] SEL_REF = 4'h4; // reference and control word
  localparam logic [3:0] SEL_FIXED = 4'h5; // fixed reserved word
  localparam logic [3:0] SEL_OUT = 4'h6; // output and bleed word
  localparam logic [3:0] SEL_LOCK = 4'h7; // lock detect word
  localparam logic [31:0] FIXED_WORD_VALUE = 32'h00800025; // required fixed contents

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [31:0] REF_CTRL_RST = 32'h00000000; // reference word after reset
  localparam logic [31:0] FIXED_RST = 32'h00000000; // fixed word after reset
  localparam logic [31:0] OUT_CTRL_RST = 32'h00000000; // output word after reset
  localparam logic [31:0] LOCK_CTRL_RST = 32'h00000000; // lock word after reset

  // ************************************************
  // lock window codes, tenths of a nanosecond
  // ************************************************
  localparam logic [7:0] WIN_5P0 = 8'h32; // 5.0 ns
  localparam logic [7:0] WIN_6P0 = 8'h3c; // 6.0 ns
  localparam logic [7:0] WIN_8P0 = 8'h50; // 8.0 ns
  localparam logic [7:0] WIN_12P0 = 8'h78; // 12.0 ns
  localparam logic [7:0] WIN_2P9 = 8'h1d; // 2.9 ns, integer mode

  // ************************************************
  // register layouts
  // ************************************************
  typedef struct packed {
    logic [1:0] rsvd_hi; // 31:30
    logic [2:0] mux_sel; // 29:27
    logic ref_doubler_en; // 26
    logic ref_halver_en; // 25
    logic [9:0] r_count; // 24:15
    logic divsel_buffer_en; // 14
    logic [3:0] pump_current; // 13:10
    logic ref_mode; // 9
    logic level_sel; // 8
    logic pd_polarity; // 7
    logic power_down_bit; // 6
    logic pump_tristate; // 5
    logic counter_reset_bit; // 4
    logic [3:0] reg_select_bits; // 3:0
  } srl_ref_ctrl_t;

  typedef struct packed {
    logic rsvd_31; // 31
    logic gated_bleed_en; // 30
    logic negative_bleed_en; // 29
    logic [3:0] rsvd_28_25; // 28:25
    logic feedback_select; // 24
    logic [2:0] out_divider_sel; // 23:21
    logic [7:0] bleed_level; // 20:13
    logic rsvd_12; // 12
    logic mute_until_lock; // 11
    logic rsvd_10; // 10
    logic aux_out_en; // 9
    logic [1:0] aux_power; // 8:7
    logic main_out_en; // 6
    logic [1:0] main_power; // 5:4
    logic [3:0] reg_select_bits; // 3:0
  } srl_out_ctrl_t;

  typedef struct packed {
    logic [5:0] rsvd_hi; // 31:26
    logic load_sync_en; // 25
    logic [14:0] rsvd_mid; // 24:10
    logic [1:0] lock_count_sel; // 9:8
    logic ref_loss_mode; // 7
    logic [1:0] lock_window_sel; // 6:5
    logic lock_cycle_mode; // 4
    logic [3:0] reg_select_bits; // 3:0
  } srl_lock_ctrl_t;

  // load sequencing, gray along idle -> wait
  typedef enum logic [1:0] {
    SRL_IDLE = 2'b00,
    SRL_WAIT_REF = 2'b01
  } srl_load_st_t;

  // serial word carrier
  typedef struct packed {
    logic valid; // one-cycle pulse
    logic [31:0] data; // latched word
  } srl_word_t;
endpackage : srl_pkg

// ===== core/srl_shift.sv
// srl_shift: three-wire serial shifter, latches a word on the load strobe rising edge
`timescale 1ns/100ps
module srl_shift (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic clk_en, // freezes state when low
  input wire logic ser_clk, // serial data clock
  input wire logic ser_data, // serial data, msb first
  input wire logic latch_strobe, // load strobe
  output srl_pkg::srl_word_t word // latched word and pulse
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic sclk_prev; // last serial clock level
    logic le_prev; // last strobe level
    logic [31:0] shift; // shift register
    srl_pkg::srl_word_t word; // output word
  } srl_shift_st_t;

  srl_shift_st_t st; // registered state
  srl_shift_st_t next_st; // next state

  // shift on serial clock rise, latch on strobe rise
  always_comb begin
    next_st = st;
    next_st.sclk_prev = ser_clk;
    next_st.le_prev = latch_strobe;
    next_st.word.valid = 1'b0;
    if (ser_clk && !st.sclk_prev) begin // shift one bit
      next_st.shift = {st.shift[30:0], ser_data};
    end
    if (latch_strobe && !st.le_prev) begin // whole word latched
      next_st.word.valid = 1'b1;
      next_st.word.data = st.shift;
    end
  end

  // register the state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign word = st.word;
endmodule : srl_shift

// ===== core/srl_core.sv
// srl_core: reference path, output stage, bleed and lock detect configuration
`timescale 1ns/100ps
// Contract
// - select bits route word to register
// - doubler: both edges, else falling only
// - halver toggles divider output, 50% duty
// - ten-bit reference divider, ratios 1-1023
// - buffered divider select waits register 0
// - power down stops counters, lock, outputs
// - tristate bit floats charge pump
// - counter reset holds dividers, band select
// - gated bleed waits for lock
// - negative bleed enable bit
// - feedback from oscillator or divider chain
// - divider select and bleed level fields
// - mute output supply until lock
// - auxiliary output enable and power
// - primary output enable and power
// - load sync to rising reference edge
// - lock count selects cycles before lock
// - reference loss mode clears lock detect
// - fractional window 5, 6, 8, 12 ns
// - cycle mode picks fixed 2.9 ns window
// - frequency applies only on register 0
module srl_core #(
  parameter logic [13:0] LOCK_CNT_0 = 14'h0400, // cycles for lock count code 0
  parameter logic [13:0] LOCK_CNT_1 = 14'h0800, // cycles for lock count code 1
  parameter logic [13:0] LOCK_CNT_2 = 14'h1000, // cycles for lock count code 2
  parameter logic [13:0] LOCK_CNT_3 = 14'h2000, // cycles for lock count code 3
  parameter logic [15:0] REF_LOSS_CYCLES = 16'h0400 // clk_sys cycles without ref edge = loss
) (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic rst_b, // sync reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic ser_clk, // serial data clock
  input wire logic ser_data, // serial data
  input wire logic latch_strobe, // serial load strobe
  input wire logic ref_in, // reference input, sampled
  input wire logic phase_in_window, // phase error inside lock window
  output logic pd_ref_tick, // phase detector reference pulse
  output logic ref_halver, // halver flip-flop level
  output logic freq_apply, // frequency update pulse
  output logic divider_load, // divider load pulse
  output logic counter_reset, // holds n divider and band select
  output logic pump_hiz, // charge pump in high impedance
  output logic bleed_on, // bleed current switched on
  output logic [7:0] bleed_level, // bleed current level
  output logic feedback_select, // 1 feedback from oscillator
  output logic [2:0] out_divider_sel, // active output divider select
  output logic osc_power_on, // oscillator powered
  output logic main_out_on, // primary output enabled
  output logic [1:0] main_power, // primary output power
  output logic aux_out_on, // auxiliary output enabled
  output logic [1:0] aux_power, // auxiliary output power
  output logic lock_detect, // digital lock indication
  output logic [7:0] lock_window, // window, tenths of ns
  output logic fixed_word_ok // fixed word holds its value
);
  // ************************************************
  // serial front end
  // ************************************************
  srl_pkg::srl_word_t word; // latched word from shifter

  srl_shift u_shift (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .latch_strobe(latch_strobe),
    .word(word)
  );

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    srl_pkg::srl_ref_ctrl_t ref_r; // reference and control word
    logic [31:0] fixed_r; // fixed reserved word
    srl_pkg::srl_out_ctrl_t out_r; // output and bleed word
    srl_pkg::srl_lock_ctrl_t lock_r; // lock detect word
    logic [2:0] divsel_act; // divider select in use
    srl_pkg::srl_load_st_t load_st; // load sequencing
    logic ref_prev; // last reference level
    logic [9:0] rcnt; // reference divider count
    logic half_t; // halver flip-flop
    logic pfd_tick; // phase detector pulse
    logic [13:0] lock_cnt; // consecutive in-window cycles
    logic locked; // lock flag
    logic [15:0] loss_cnt; // cycles since last ref edge
    logic freq_upd; // frequency apply pulse
    logic div_load; // divider load pulse
  } srl_core_st_t;

  srl_core_st_t st; // registered state
  srl_core_st_t next_st; // next state

  // ************************************************
  // combinational helpers
  // ************************************************
  logic ref_rise; // reference rising edge
  logic ref_fall; // reference falling edge
  logic ref_active; // active edge into divider
  logic [9:0] r_ratio; // effective divider ratio
  logic r_out; // divider output pulse
  logic hold_cnt; // dividers held
  logic [13:0] lock_need; // selected lock count
  logic ref_lost; // reference absent

  // edge and divider terms
  always_comb begin
    ref_rise = ref_in && !st.ref_prev;
    ref_fall = !ref_in && st.ref_prev;
    // doubler on: both edges active, off: falling only
    ref_active = st.ref_r.ref_doubler_en ? (ref_rise || ref_fall) : ref_fall;
    // ratio zero is treated as one
    r_ratio = (st.ref_r.r_count == 10'h000) ? 10'h001 : st.ref_r.r_count;
    r_out = ref_active && (st.rcnt >= (r_ratio - 10'h001));
    // power down and counter reset hold dividers
    hold_cnt = st.ref_r.power_down_bit || st.ref_r.counter_reset_bit;
    // lock count selection
    case (st.lock_r.lock_count_sel)
      2'b00: lock_need = LOCK_CNT_0;
      2'b01: lock_need = LOCK_CNT_1;
      2'b10: lock_need = LOCK_CNT_2;
      default: lock_need = LOCK_CNT_3;
    endcase
    ref_lost = (st.loss_cnt >= REF_LOSS_CYCLES);
  end

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    next_st = st;
    next_st.ref_prev = ref_in;
    next_st.freq_upd = 1'b0;
    next_st.div_load = 1'b0;
    next_st.pfd_tick = 1'b0;

    // register writes; input registers stay live in power down
    if (word.valid) begin
      case (word.data[3:0])
        srl_pkg::SEL_REF: next_st.ref_r = word.data;
        srl_pkg::SEL_FIXED: next_st.fixed_r = word.data;
        srl_pkg::SEL_OUT: begin
          next_st.out_r = word.data;
          if (!st.ref_r.divsel_buffer_en) begin // unbuffered select
            next_st.divsel_act = word.data[23:21];
          end
        end
        srl_pkg::SEL_LOCK: next_st.lock_r = word.data;
        srl_pkg::SEL_FREQ: begin // frequency update and buffered divider select apply here, or at the next rising ref edge when load sync is on
          if (st.lock_r.load_sync_en) begin // wait rising ref edge
            next_st.load_st = srl_pkg::SRL_WAIT_REF;
          end else begin
            next_st.load_st = srl_pkg::SRL_IDLE;
            next_st.freq_upd = 1'b1;
            next_st.div_load = 1'b1;
            next_st.divsel_act = st.out_r.out_divider_sel;
          end
        end
        default: begin
          // other words belong elsewhere
        end
      endcase
    end

    // deferred load on rising reference edge
    case (st.load_st)
      srl_pkg::SRL_IDLE: begin
        // nothing pending
      end
      srl_pkg::SRL_WAIT_REF: begin
        if (ref_rise && !(word.valid && word.data[3:0] == srl_pkg::SEL_FREQ)) begin
          next_st.load_st = srl_pkg::SRL_IDLE;
          next_st.freq_upd = 1'b1;
          next_st.div_load = 1'b1;
          next_st.divsel_act = st.out_r.out_divider_sel;
        end
      end
      default: next_st.load_st = srl_pkg::SRL_IDLE;
    endcase

    // reference divider and halver
    if (hold_cnt) begin // load state while held
      next_st.rcnt = 10'h000;
      next_st.half_t = 1'b0;
    end else if (ref_active) begin
      if (r_out) begin // divider wraps
        next_st.rcnt = 10'h000;
        if (st.ref_r.ref_halver_en) begin // toggle stage
          next_st.half_t = !st.half_t;
          next_st.pfd_tick = !st.half_t;
        end else begin
          next_st.half_t = 1'b0;
          next_st.pfd_tick = 1'b1;
        end
      end else begin
        next_st.rcnt = st.rcnt + 10'h001;
      end
    end

    // reference presence watchdog
    if (ref_rise || ref_fall) begin
      next_st.loss_cnt = 16'h0000;
    end else if (!ref_lost) begin
      next_st.loss_cnt = st.loss_cnt + 16'h0001;
    end

    // lock detector
    if (st.ref_r.power_down_bit) begin // lock resets in power down
      next_st.lock_cnt = 14'h0000;
      next_st.locked = 1'b0;
    end else if (st.lock_r.ref_loss_mode && ref_lost) begin // reference removed
      next_st.lock_cnt = 14'h0000;
      next_st.locked = 1'b0;
    end else if (st.pfd_tick) begin
      if (!phase_in_window) begin // out of window restarts count
        next_st.lock_cnt = 14'h0000;
        next_st.locked = 1'b0;
      end else if (st.lock_cnt >= (lock_need - 14'h0001)) begin // count reached
        next_st.locked = 1'b1;
      end else begin
        next_st.lock_cnt = st.lock_cnt + 14'h0001;
      end
    end
  end

  // register the state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st.ref_r <= srl_pkg::REF_CTRL_RST;
      st.fixed_r <= srl_pkg::FIXED_RST;
      st.out_r <= srl_pkg::OUT_CTRL_RST;
      st.lock_r <= srl_pkg::LOCK_CTRL_RST;
      st.divsel_act <= 3'h0;
      st.load_st <= srl_pkg::SRL_IDLE;
      st.ref_prev <= 1'b0;
      st.rcnt <= 10'h000;
      st.half_t <= 1'b0;
      st.pfd_tick <= 1'b0;
      st.lock_cnt <= 14'h0000;
      st.locked <= 1'b0;
      st.loss_cnt <= 16'h0000;
      st.freq_upd <= 1'b0;
      st.div_load <= 1'b0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  // window selection per reference cycle
  always_comb begin
    if (st.lock_r.lock_cycle_mode) begin // fixed integer window
      lock_window = srl_pkg::WIN_2P9;
    end else begin
      case (st.lock_r.lock_window_sel) // fractional window
        2'b00: lock_window = srl_pkg::WIN_5P0;
        2'b01: lock_window = srl_pkg::WIN_6P0;
        2'b10: lock_window = srl_pkg::WIN_8P0;
        default: lock_window = srl_pkg::WIN_12P0;
      endcase
    end
  end

  assign pd_ref_tick = st.pfd_tick;
  assign ref_halver = st.half_t;
  assign freq_apply = st.freq_upd;
  assign divider_load = st.div_load;
  assign counter_reset = st.ref_r.counter_reset_bit || st.ref_r.power_down_bit;
  assign pump_hiz = st.ref_r.pump_tristate || st.ref_r.power_down_bit;
  // gated bleed waits for lock
  assign bleed_on = st.out_r.negative_bleed_en && !st.ref_r.power_down_bit
    && (!st.out_r.gated_bleed_en || st.locked);
  assign bleed_level = st.out_r.bleed_level;
  assign feedback_select = st.out_r.feedback_select;
  assign out_divider_sel = st.divsel_act;
  assign osc_power_on = !st.ref_r.power_down_bit;
  // supply muted until lock, off in power down
  assign main_out_on = st.out_r.main_out_en && !st.ref_r.power_down_bit
    && (!st.out_r.mute_until_lock || st.locked);
  assign main_power = st.out_r.main_power;
  // auxiliary output shares the muted supply
  assign aux_out_on = st.out_r.aux_out_en && !st.ref_r.power_down_bit
    && (!st.out_r.mute_until_lock || st.locked);
  assign aux_power = st.out_r.aux_power;
  assign lock_detect = st.locked;
  assign fixed_word_ok = (st.fixed_r == srl_pkg::FIXED_WORD_VALUE);
endmodule : srl_core

// ===== sim/srl_host_model.sv
// srl_host_model: host controller shifting 32-bit words over the three-wire port
`timescale 1ns/100ps
module srl_host_model (
  input wire logic clk_sys, // system clock
  input wire logic go, // start one word
  input wire logic [31:0] word_in, // word to send
  output logic ser_clk, // serial clock, still outside frames
  output logic ser_data, // serial data, msb first
  output logic latch_strobe, // load strobe
  output logic busy // frame in progress
);
  // ********
  // frame state
  // ********
  logic [31:0] shreg; // bits still to send
  int ph; // quarter-bit phase

  // idle lines at time zero
  initial begin
    ser_clk = 0;
    ser_data = 0;
    latch_strobe = 0;
    busy = 0;
    ph = 0;
  end

  // ********
  // sequencer: data, clock high two cycles, clock low, then strobe
  // ********
  always @(posedge clk_sys) begin
    if (!busy && go) begin
      busy <= 1;
      shreg <= word_in;
      ph <= 0;
    end else if (busy) begin
      ph <= ph + 1;
      if (ph < 128) begin
        case (ph % 4)
          0: ser_data <= shreg[31]; // bit 31 first
          1: ser_clk <= 1;
          3: begin
            ser_clk <= 0;
            shreg <= {shreg[30:0], 1'b0};
          end
          default: ;
        endcase
      end else if (ph == 129) begin
        latch_strobe <= 1; // latch after all 32 bits
        ser_data <= ~ser_data; // released line shows no stale bit
      end else if (ph == 131) begin
        latch_strobe <= 0;
      end else if (ph == 133) begin
        busy <= 0;
      end
    end
  end
endmodule : srl_host_model

// ===== sim/srl_core_sva.sv
// srl_core_sva: output and timing assertions for the synthesizer config block
`timescale 1ns/100ps
module srl_core_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic phase_in_window,
  input wire logic pd_ref_tick,
  input wire logic freq_apply,
  input wire logic divider_load,
  input wire logic counter_reset,
  input wire logic pump_hiz,
  input wire logic bleed_on,
  input wire logic osc_power_on,
  input wire logic main_out_on,
  input wire logic aux_out_on,
  input wire logic lock_detect,
  input wire logic [7:0] lock_window
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // ********
  // properties
  // ********
  property p_pd_out;
    !osc_power_on |-> pump_hiz && counter_reset && !main_out_on && !aux_out_on && !bleed_on;
  endproperty
  property p_pd_lock;
    !osc_power_on && !$past(osc_power_on) |-> !lock_detect;
  endproperty
  property p_hold;
    counter_reset [*3] |=> !pd_ref_tick;
  endproperty
  property p_apply_pair;
    freq_apply || divider_load |-> freq_apply && divider_load;
  endproperty
  property p_apply_pulse;
    freq_apply |=> !freq_apply;
  endproperty
  property p_lock_rise;
    $rose(lock_detect) |-> $past(pd_ref_tick) && $past(phase_in_window);
  endproperty
  property p_lock_drop;
    pd_ref_tick && !phase_in_window |=> !lock_detect;
  endproperty
  property p_window;
    lock_window inside {8'h32, 8'h3c, 8'h50, 8'h78, 8'h1d};
  endproperty

  // ********
  // assertions and covers
  // ********
  a_pd_out: assert property (p_pd_out)
    else $error("power down left an output active");
  a_pd_lock: assert property (p_pd_lock)
    else $error("lock held during power down");
  a_hold: assert property (p_hold)
    else $error("reference tick during counter reset");
  a_apply_pair: assert property (p_apply_pair)
    else $error("apply and divider load apart");
  a_apply_pulse: assert property (p_apply_pulse)
    else $error("apply pulse longer than one cycle");
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock rose without in-window tick");
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock kept after out-of-window tick");
  a_window: assert property (p_window)
    else $error("lock window code out of set");
  c_lock: cover property ($rose(lock_detect));
  c_apply: cover property (freq_apply);
  c_bleed: cover property (bleed_on && lock_detect);
endmodule : srl_core_sva

bind srl_core srl_core_sva sva_u (.clk_sys, .rst_b, .phase_in_window, .pd_ref_tick, .freq_apply, .divider_load,
  .counter_reset, .pump_hiz, .bleed_on, .osc_power_on, .main_out_on, .aux_out_on, .lock_detect, .lock_window);

// ===== sim/tb_synth_ref_output_lock_config.sv
// tb_synth_ref_output_lock_config: self-checking bench for the synthesizer config block
`timescale 1ns/100ps
module tb_synth_ref_output_lock_config;
  // ********
  // signals
  // ********
  logic clk_sys, rst_b, clk_en, ref_in, phase_in_window, go, busy, ser_clk, ser_data, latch_strobe;
  logic pd_ref_tick, ref_halver, freq_apply, divider_load, counter_reset, pump_hiz, bleed_on;
  logic feedback_select, osc_power_on, main_out_on, aux_out_on, lock_detect, fixed_word_ok;
  logic [31:0] word_in; // word for the host
  logic [7:0] bleed_level, lock_window;
  logic [2:0] out_divider_sel, ds;
  logic [1:0] main_power, aux_power, ref_cnt;
  logic sync_on, ref_d, ref_dd, ref_stop; // sync expected, two ref samples, ref halted
  logic [2:0] exp_q[$]; // divider select due at each apply
  int n_errors = 0;
  int total_checks = 0;
  int g, n;
  int ratio[5] = '{1, 1, 5, 1, 1023};
  int span[5] = '{6, 3, 30, 12, 3069};
  logic [7:0] win[5] = '{8'h32, 8'h3c, 8'h50, 8'h78, 8'h1d};
  srl_pkg::srl_ref_ctrl_t rw;
  srl_pkg::srl_out_ctrl_t ow;
  srl_pkg::srl_lock_ctrl_t lw;

  srl_core #(.LOCK_CNT_0(14'h0002), .LOCK_CNT_1(14'h0003), .LOCK_CNT_2(14'h0004), .LOCK_CNT_3(14'h0005),
    .REF_LOSS_CYCLES(16'h0010)) dut_u (.clk_sys, .rst_b, .clk_en, .ser_clk, .ser_data, .latch_strobe,
    .ref_in, .phase_in_window, .pd_ref_tick, .ref_halver, .freq_apply, .divider_load, .counter_reset,
    .pump_hiz, .bleed_on, .bleed_level, .feedback_select, .out_divider_sel, .osc_power_on, .main_out_on,
    .main_power, .aux_out_on, .aux_power, .lock_detect, .lock_window, .fixed_word_ok);
  srl_host_model host_u (.clk_sys, .go, .word_in, .ser_clk, .ser_data, .latch_strobe, .busy);

  // ********
  // clock, reference of six cycles, watchdog
  // ********
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    ref_cnt <= (ref_cnt == 2) ? 2'h0 : ref_cnt + 2'h1;
    if (ref_cnt == 2 && !ref_stop) ref_in <= ~ref_in;
  end
  initial begin
    #(40000 * 10);
    n_errors++;
    conclude();
  end

  // ********
  // tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [31:0] w);
    @(posedge clk_sys);
    go <= 1;
    word_in <= w;
    @(posedge clk_sys);
    go <= 0;
    @(posedge clk_sys);
    for (int i = 0; i < 300 && busy !== 0; i++) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
  endtask : wr
  task automatic gap(output int v);
    for (int t = 0; t < 8000 && pd_ref_tick !== 1; t++) @(posedge clk_sys);
    @(posedge clk_sys);
    for (v = 1; v < 8000 && pd_ref_tick !== 1; v++) @(posedge clk_sys);
  endtask : gap
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // ********
  // apply monitor: pops the oldest expected select
  // ********
  always @(posedge clk_sys) begin
    ref_d <= ref_in;
    ref_dd <= ref_d;
    if (freq_apply === 1) begin
      check("divider_load", divider_load, 1);
      if (exp_q.size() == 0) check("apply_unexpected", 1, 0);
      else check("out_divider_sel", out_divider_sel, exp_q.pop_front());
      if (sync_on) check("ref_before_apply", {ref_dd, ref_d}, 2'b01);
    end
  end

  // ********
  // main sequence
  // ********
  initial begin
    rst_b = 0;
    clk_en = 1;
    ref_in = 0;
    ref_cnt = 0;
    phase_in_window = 0;
    go = 0;
    word_in = 0;
    sync_on = 0;
    ref_stop = 0;
    n = $urandom(42);
    repeat (8) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    check("pump_hiz", pump_hiz, 0);
    check("osc_power_on", osc_power_on, 1);
    check("fixed_word_ok", fixed_word_ok, 0);
    wr(srl_pkg::FIXED_WORD_VALUE);
    check("fixed_word_ok", fixed_word_ok, 1);
    wr(32'h00000009);
    check("fixed_word_ok", fixed_word_ok, 1);
    $display("test reset and fixed word done");
    for (int k = 0; k < 3; k++) begin
      ow = srl_pkg::srl_out_ctrl_t'($urandom);
      ow.mute_until_lock = 0;
      ow.gated_bleed_en = 0;
      ow.reg_select_bits = srl_pkg::SEL_OUT;
      wr(ow);
      check("bleed_level", bleed_level, ow.bleed_level);
      check("out_divider_sel", out_divider_sel, ow.out_divider_sel);
      check("feedback_select", feedback_select, ow.feedback_select);
      check("main_out_on", main_out_on, ow.main_out_en);
      check("main_power", main_power, ow.main_power);
      check("aux_out_on", aux_out_on, ow.aux_out_en);
      check("aux_power", aux_power, ow.aux_power);
      check("bleed_on", bleed_on, ow.negative_bleed_en);
    end
    $display("test output word done");
    for (int b = 0; b < 4; b++) begin
      rw = '0;
      rw.reg_select_bits = srl_pkg::SEL_REF;
      rw.r_count = 10'h001;
      rw.pump_tristate = (b == 0);
      rw.counter_reset_bit = (b == 1); // set then cleared
      rw.power_down_bit = (b == 2);
      wr(rw);
      check("pump_hiz", pump_hiz, b == 0 || b == 2);
      check("counter_reset", counter_reset, b == 1 || b == 2);
      check("osc_power_on", osc_power_on, b != 2);
      check("main_out_on", main_out_on, (b != 2) & ow.main_out_en);
    end
    $display("test control bits done");
    for (int j = 0; j < 5; j++) begin
      rw.ref_doubler_en = (j == 1 || j == 4);
      rw.ref_halver_en = (j == 3);
      rw.r_count = ratio[j][9:0];
      wr(rw);
      gap(g);
      gap(g);
      check("tick_gap", g, span[j]);
      check("ref_halver", ref_halver, j == 3);
    end
    rw.ref_doubler_en = 0;
    rw.r_count = 10'h001;
    wr(rw);
    $display("test reference path done");
    for (int w = 0; w < 5; w++) begin
      lw = '0;
      lw.reg_select_bits = srl_pkg::SEL_LOCK;
      lw.lock_window_sel = w[1:0];
      lw.lock_cycle_mode = (w == 4);
      wr(lw);
      check("lock_window", lock_window, win[w]);
    end
    for (int c = 0; c < 4; c++) begin
      lw.lock_count_sel = c[1:0];
      phase_in_window <= 0;
      wr(lw);
      phase_in_window <= 1;
      n = 0;
      for (int t = 0; t < 400 && lock_detect !== 1; t++) begin
        @(posedge clk_sys);
        if (pd_ref_tick === 1 && lock_detect === 0) n++;
      end
      check("lock_ticks", n, c + 2);
    end
    lw.ref_loss_mode = 1;
    wr(lw);
    check("lock_detect", lock_detect, 1);
    ref_stop <= 1;
    repeat (40) @(posedge clk_sys);
    check("lock_detect", lock_detect, 0);
    ref_stop <= 0;
    lw.ref_loss_mode = 0;
    wr(lw);
    $display("test lock detect done");
    ow.mute_until_lock = 1;
    ow.gated_bleed_en = 1;
    ow.negative_bleed_en = 1;
    ow.main_out_en = 1;
    wr(ow);
    check("main_out_on", main_out_on, 1);
    check("bleed_on", bleed_on, 1);
    phase_in_window <= 0;
    for (int t = 0; t < 40 && lock_detect !== 0; t++) @(posedge clk_sys);
    check("lock_detect", lock_detect, 0);
    check("main_out_on", main_out_on, 0);
    check("bleed_on", bleed_on, 0);
    $display("test mute and gated bleed done");
    rw.divsel_buffer_en = 1;
    wr(rw);
    for (int s = 0; s < 2; s++) begin
      lw.load_sync_en = s[0];
      sync_on = s[0];
      wr(lw);
      ds = ow.out_divider_sel;
      ow.out_divider_sel = ds + 3'h1;
      wr(ow);
      check("out_divider_sel", out_divider_sel, ds);
      exp_q.push_back(ow.out_divider_sel);
      wr({28'h0000123, srl_pkg::SEL_FREQ});
      check("pending_apply", exp_q.size(), 0);
    end
    $display("test double buffer and apply done");
    conclude();
  end
endmodule : tb_synth_ref_output_lock_config
